// ==== rtl/opds_delay_unit.sv ====
/*
  One delay channel: the output follows the gated level after an on
  or off delay given in core clock cycles.
  Assumes the level input is a registered signal of the same clock.
*/
`timescale 1ns/1ns
`include "opds_regs.svh"

module opds_delay_unit
  import opds_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  input  wire logic                   level,
  input  wire logic [`OPDS_CNT_W-1:0] on_cyc,
  input  wire logic [`OPDS_CNT_W-1:0] off_cyc,
  output logic                        dly_out
);

  localparam opds_dly_type RST = '{default: '0};

  opds_dly_type                       s_r;
  opds_dly_type                       s_nxt;
  logic         [`OPDS_CNT_W-1:0]     dly;

  // pick the delay of the new direction
  assign dly = level ? on_cyc : off_cyc;

  // edge starts a count; a reversed edge restarts it
  always_comb begin
    s_nxt = s_r;
    if (level != s_r.prev) begin
      s_nxt.prev = level;
      if (dly == '0) begin
        s_nxt.out  = level;
        s_nxt.busy = 1'b0;
      end else begin
        s_nxt.cnt  = dly - 1'b1;
        s_nxt.busy = 1'b1;
      end
    end else if (s_r.busy) begin
      if (s_r.cnt == '0) begin
        s_nxt.out  = s_r.prev;
        s_nxt.busy = 1'b0;
      end else begin
        s_nxt.cnt = s_r.cnt - 1'b1;
      end
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r <= RST;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign dly_out = s_r.out;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence edge_zero_s;
    clk_en && level != s_r.prev && dly == '0;
  endsequence

  zero_delay_a: assert property (edge_zero_s |=> dly_out == s_r.prev)
    else $error("zero code did not pass the level at once");
  count_load_a: assert property (clk_en && level != s_r.prev
      && dly != '0 |=> s_r.busy && s_r.cnt == $past(dly) - 1'b1)
    else $error("delay count not loaded from code");
  out_hold_a: assert property (clk_en && s_r.busy && s_r.cnt != '0
      && level == s_r.prev |=> dly_out == $past(dly_out))
    else $error("output moved before the delay ran out");

endmodule // opds_delay_unit

// ==== rtl/opds_top.sv ====
/*
  Output pin delay sequencer: four option registers and a range and a
  status register on AXI4-Lite, gating and pin drivers for outputs
  A, B and C, delays for B and C. Assumes enable and clock pins are asynchronous,
  the power-good level and OTP defaults come from same-clock logic.
*/
`timescale 1ns/1ns
`include "opds_regs.svh"

module opds_top
  import opds_pkg::*;
#(
  parameter int STEP_LO_CYC = `OPDS_STEP_LO_US * `OPDS_CLK_MHZ,
  parameter int STEP_HI_CYC = `OPDS_STEP_HI_US * `OPDS_CLK_MHZ
)(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        enable_pin_one,
  input  wire logic        enable_pin_two,
  input  wire logic        enable_pin_three,
  input  wire logic        ext_sync_clock_pin,
  input  wire logic        power_good_b,
  input  wire logic [7:0]  otp_b_delay,
  input  wire logic [7:0]  otp_c_delay,
  input  wire logic [7:0]  otp_ctrl_first,
  input  wire logic [7:0]  otp_ctrl_second,
  output logic             output_a_o,
  output logic             output_a_oe,
  output logic             output_b_o,
  output logic             output_b_oe,
  output logic             output_c_o,
  output logic             output_c_oe
);

  typedef logic [`OPDS_CNT_W-1:0] opds_cnt_type;

  // refuse step counts that overflow the delay counter
  if (STEP_LO_CYC < 1 || STEP_HI_CYC < STEP_LO_CYC ||
      longint'(STEP_HI_CYC) * `OPDS_CODE_MAX >=
      (longint'(1) << `OPDS_CNT_W)) begin : g_bad_step
    $error("step counts do not fit the delay counter");
  end

  localparam opds_cnt_type LO_STEP = opds_cnt_type'(STEP_LO_CYC);
  localparam opds_cnt_type HI_STEP = opds_cnt_type'(STEP_HI_CYC);

  localparam opds_top_type RST = '{
    b_dly:  `OPDS_RST_B_DLY,
    c_dly:  `OPDS_RST_C_DLY,
    ctrl1:  `OPDS_RST_CTRL1,
    ctrl2:  `OPDS_RST_CTRL2,
    otp_pend: 1'b1,
    aw_rdy: 1'b1,
    w_rdy:  1'b1,
    ar_rdy: 1'b1,
    default: '0
  };

  opds_top_type                s_r;
  opds_top_type                s_nxt;
  opds_cnt_type                on_step;
  opds_cnt_type                off_step;
  opds_cnt_type                b_on_cyc;
  opds_cnt_type                b_off_cyc;
  opds_cnt_type                c_on_cyc;
  opds_cnt_type                c_off_cyc;
  logic                        lvl_a;
  logic                        lvl_b;
  logic                        lvl_c;
  logic                        dly_b;
  logic                        dly_c;
  logic          [7:0]         status;

  // level ANDed with the chosen enable pin, or alone for select 0
  function automatic logic gate(input logic [1:0] sel,
                                input logic       lvl,
                                input logic [2:0] en);
    logic g;
    g = lvl;
    case (sel)
      2'h0:    g = lvl;
      2'h1:    g = lvl & en[0];
      2'h2:    g = lvl & en[1];
      2'h3:    g = lvl & en[2];
      default: g = lvl;
    endcase
    return g;
  endfunction

  // pin level and enable: push-pull always drives, open-drain pulls low
  function automatic logic [1:0] drive(input logic od,
                                       input logic lvl);
    return od ? {1'b0, ~lvl} : {lvl, 1'b1};
  endfunction

  // register read mux
  function automatic logic [7:0] rd_mux(input opds_top_type s,
                                        input logic [5:0]   idx,
                                        input logic [7:0]   st);
    logic [7:0] d;
    d = 8'h00;
    case (idx)
      `OPDS_IDX_B_DLY:  d = s.b_dly;
      `OPDS_IDX_C_DLY:  d = s.c_dly;
      `OPDS_IDX_CTRL1:  d = s.ctrl1;
      `OPDS_IDX_CTRL2:  d = s.ctrl2;
      `OPDS_IDX_RANGE:  d = {s.rng, 6'h00};
      `OPDS_IDX_STATUS: d = st;
      default:          d = 8'h00;
    endcase
    return d;
  endfunction

  // mapped addresses answer okay, others a slave error
  function automatic logic hit(input logic [5:0] idx);
    return idx == `OPDS_IDX_B_DLY || idx == `OPDS_IDX_C_DLY ||
           idx == `OPDS_IDX_CTRL1 || idx == `OPDS_IDX_CTRL2 ||
           idx == `OPDS_IDX_RANGE || idx == `OPDS_IDX_STATUS;
  endfunction

  // step size from the two range bits
  assign on_step  = s_r.rng[`OPDS_RNG_ON] ? HI_STEP : LO_STEP;
  assign off_step = (s_r.rng[`OPDS_RNG_ON] | s_r.rng[`OPDS_RNG_OFF])
                    ? HI_STEP : LO_STEP;

  // delay in cycles is code times step
  assign b_on_cyc  = opds_cnt_type'(s_r.b_dly[`OPDS_DLY_ON +: 4])
                     * on_step;
  assign b_off_cyc = opds_cnt_type'(s_r.b_dly[`OPDS_DLY_OFF +: 4])
                     * off_step;
  assign c_on_cyc  = opds_cnt_type'(s_r.c_dly[`OPDS_DLY_ON +: 4])
                     * on_step;
  assign c_off_cyc = opds_cnt_type'(s_r.c_dly[`OPDS_DLY_OFF +: 4])
                     * off_step;

  // gated levels from level bits and synchronised enable pins
  assign lvl_a = gate(s_r.ctrl1[`OPDS_C1_A_GATE +: 2],
                      s_r.ctrl1[`OPDS_C1_A_LVL], s_r.en_s);
  assign lvl_b = gate(s_r.ctrl1[`OPDS_C1_B_GATE +: 2],
                      s_r.ctrl1[`OPDS_C1_B_LVL], s_r.en_s);
  assign lvl_c = gate(s_r.ctrl2[`OPDS_C2_C_GATE +: 2],
                      s_r.ctrl2[`OPDS_C2_C_LVL], s_r.en_s);

  // delay channels of outputs B and C
  opds_delay_unit u_dly_b (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .level    (lvl_b),
    .on_cyc   (b_on_cyc),
    .off_cyc  (b_off_cyc),
    .dly_out  (dly_b)
  );

  opds_delay_unit u_dly_c (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .level    (lvl_c),
    .on_cyc   (c_on_cyc),
    .off_cyc  (c_off_cyc),
    .dly_out  (dly_c)
  );

  // live state seen by software
  assign status = {1'b0, power_good_b, s_r.clk_s, dly_c, lvl_c,
                   dly_b, lvl_b, lvl_a};

  // next state: synchronisers, bus slave, OTP load and pin drivers
  always_comb begin
    s_nxt = s_r;
    // two-stage synchronisers for the asynchronous pins
    s_nxt.en_m  = {enable_pin_three, enable_pin_two, enable_pin_one};
    s_nxt.en_s  = s_r.en_m;
    s_nxt.clk_m = ext_sync_clock_pin;
    s_nxt.clk_s = s_r.clk_m;
    // write address and data, taken in either order
    if (s_axi_awvalid && s_r.aw_rdy) begin
      s_nxt.aw_idx = s_axi_awaddr[7:2];
      s_nxt.aw_rdy = 1'b0;
    end
    if (s_axi_wvalid && s_r.w_rdy) begin
      s_nxt.w_dat = s_axi_wdata[7:0];
      s_nxt.w_stb = s_axi_wstrb[0];
      s_nxt.w_rdy = 1'b0;
    end
    // both held: store and answer
    if (!s_r.aw_rdy && !s_r.w_rdy && !s_r.bvalid) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = hit(s_r.aw_idx) ? `OPDS_RESP_OKAY
                                     : `OPDS_RESP_SLVERR;
      if (s_r.w_stb) begin
        case (s_r.aw_idx)
          `OPDS_IDX_B_DLY: s_nxt.b_dly = s_r.w_dat;
          `OPDS_IDX_C_DLY: s_nxt.c_dly = s_r.w_dat;
          `OPDS_IDX_CTRL1: s_nxt.ctrl1 = s_r.w_dat;
          `OPDS_IDX_CTRL2: s_nxt.ctrl2 = s_r.w_dat;
          `OPDS_IDX_RANGE:
            s_nxt.rng = s_r.w_dat[`OPDS_RNG_POS +: 2];
          default: s_nxt.rng = s_r.rng;
        endcase
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.aw_rdy = 1'b1;
      s_nxt.w_rdy  = 1'b1;
    end
    // read: answer one cycle after the address is taken
    if (s_axi_arvalid && s_r.ar_rdy) begin
      s_nxt.ar_rdy = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_mux(s_r, s_axi_araddr[7:2], status);
      s_nxt.rresp  = hit(s_axi_araddr[7:2]) ? `OPDS_RESP_OKAY
                                            : `OPDS_RESP_SLVERR;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.ar_rdy = 1'b1;
    end
    // one-time-programmed defaults replace the reset values
    if (s_r.otp_pend) begin
      s_nxt.b_dly    = otp_b_delay;
      s_nxt.c_dly    = otp_c_delay;
      s_nxt.ctrl1    = otp_ctrl_first;
      s_nxt.ctrl2    = otp_ctrl_second;
      s_nxt.otp_pend = 1'b0;
    end
    // output A: gated level only
    {s_nxt.a_o, s_nxt.a_oe} =
      drive(s_r.ctrl1[`OPDS_C1_A_OD], lvl_a);
    // pin B: delayed output B or power-good B
    if (s_r.ctrl2[`OPDS_C2_B_FN]) begin
      {s_nxt.b_o, s_nxt.b_oe} =
        drive(s_r.ctrl1[`OPDS_C1_B_OD], dly_b);
    end else begin
      {s_nxt.b_o, s_nxt.b_oe} =
        drive(s_r.ctrl1[`OPDS_C1_B_OD], power_good_b);
    end
    // pin C: delayed output C or released as clock input
    if (s_r.ctrl2[`OPDS_C2_C_FN]) begin
      {s_nxt.c_o, s_nxt.c_oe} =
        drive(s_r.ctrl2[`OPDS_C2_C_OD], dly_c);
    end else begin
      {s_nxt.c_o, s_nxt.c_oe} = 2'b00;
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r <= RST;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state flops
  assign s_axi_awready = s_r.aw_rdy;
  assign s_axi_wready  = s_r.w_rdy;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.ar_rdy;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = {24'h00_0000, s_r.rdata};
  assign output_a_o    = s_r.a_o;
  assign output_a_oe   = s_r.a_oe;
  assign output_b_o    = s_r.b_o;
  assign output_b_oe   = s_r.b_oe;
  assign output_c_o    = s_r.c_o;
  assign output_c_oe   = s_r.c_oe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence wr_done_s(logic [5:0] idx);
    clk_en && !s_r.aw_rdy && !s_r.w_rdy && !s_r.bvalid && s_r.w_stb
    && s_r.aw_idx == idx && !s_r.otp_pend;
  endsequence

  b_delay_wr_a: assert property (wr_done_s(`OPDS_IDX_B_DLY)
      |=> s_r.b_dly == $past(s_r.w_dat))
    else $error("output B delay register not written");
  reserved_rw_a: assert property (wr_done_s(`OPDS_IDX_CTRL2)
      |=> s_r.ctrl2[7:6] == $past(s_r.w_dat[7:6]))
    else $error("reserved bits not stored as written");
  otp_load_a: assert property (!sys_rst && clk_en && s_r.otp_pend
      |=> s_r.ctrl1 == $past(otp_ctrl_first)
          && s_r.c_dly == $past(otp_c_delay))
    else $error("OTP defaults not loaded");
  pin_b_push_a: assert property (clk_en && s_r.ctrl2[`OPDS_C2_B_FN]
      && !s_r.ctrl1[`OPDS_C1_B_OD]
      |=> output_b_oe && output_b_o == $past(dly_b))
    else $error("pin B push-pull does not follow output B");
  pin_c_drain_a: assert property (clk_en && s_r.ctrl2[`OPDS_C2_C_FN]
      && s_r.ctrl2[`OPDS_C2_C_OD]
      |=> !output_c_o && output_c_oe == !$past(dly_c))
    else $error("pin C open-drain drive wrong");
  pin_c_clock_a: assert property (clk_en && !s_r.ctrl2[`OPDS_C2_C_FN]
      |=> !output_c_oe)
    else $error("pin C driven while a clock input");
  out_a_level_a: assert property (clk_en && !s_r.ctrl1[`OPDS_C1_A_OD]
      && s_r.ctrl1[`OPDS_C1_A_GATE +: 2] == 2'h0
      |=> output_a_oe && output_a_o == $past(s_r.ctrl1[0]))
    else $error("output A does not follow its level bit");
  gate_off_a: assert property (s_r.ctrl1[`OPDS_C1_B_GATE +: 2] == 2'h2
      && !s_r.en_s[1] |-> !lvl_b)
    else $error("output B not gated by enable pin two");
  step_sel_a: assert property (s_r.rng[`OPDS_RNG_ON]
      |-> off_step == HI_STEP && on_step == HI_STEP)
    else $error("startup range did not select long steps");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before taken");

endmodule // opds_top

// ==== shared/opds_pkg.sv ====
/*
  State types of the output pin delay sequencer.
  Assumes opds_regs.svh is on the include path.
*/
`include "opds_regs.svh"

package opds_pkg;

  // state of one delay channel
  typedef struct packed {
    logic                   prev;
    logic                   out;
    logic                   busy;
    logic [`OPDS_CNT_W-1:0] cnt;
  } opds_dly_type;

  // state of the top level
  typedef struct packed {
    logic [7:0] b_dly;
    logic [7:0] c_dly;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [1:0] rng;
    logic       otp_pend;
    logic [2:0] en_m;
    logic [2:0] en_s;
    logic       clk_m;
    logic       clk_s;
    logic       aw_rdy;
    logic [5:0] aw_idx;
    logic       w_rdy;
    logic [7:0] w_dat;
    logic       w_stb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       ar_rdy;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic       a_o;
    logic       a_oe;
    logic       b_o;
    logic       b_oe;
    logic       c_o;
    logic       c_oe;
  } opds_top_type;

endpackage

// ==== shared/opds_regs.svh ====
/*
  Register indices, field positions, reset values and timing figures of
  the output pin delay sequencer. Assumes a 100 MHz core clock.
*/
// Contract
// - Delay B bits 7:4 set output B off delay, 0.5 ms per code step.
// - Delay B bits 3:0 set output B on delay, 0.5 ms per code step.
// - Delay C bits 7:4 set output C off delay, coded like output B.
// - Delay C bits 3:0 set output C on delay; code zero means none.
// - First control bit 7: pin B push-pull when 0, open-drain when 1.
// - First control bits 6:5 AND output B level with enable pin 1-3.
// - First control bit 4 is output B level, 1 drives high.
// - First control bits 2:1 AND output A level with enable pin 1-3.
// - First control bit 0 is output A level, 1 drives high.
// - All four registers load their one-time-programmed defaults.
// - Second control bit 5: pin C is clock input or output C.
// - Second control bit 4: pin B is power-good B or output B.
// - Second control bit 3: output C push-pull when 0, open-drain when 1.
// - Second control bits 2:1 AND output C level with enable pin 1-3.
// - Second control bit 0 is output C level, 1 drives high.
// - Startup range bit: 0.5 ms steps when 0, 1 ms steps when 1.
// - Shutdown range bit also selects 1 ms off steps when set.
`ifndef OPDS_REGS_SVH
`define OPDS_REGS_SVH

// register indices; byte address is four times the index
`define OPDS_IDX_B_DLY   6'h0d
`define OPDS_IDX_C_DLY   6'h0e
`define OPDS_IDX_CTRL1   6'h0f
`define OPDS_IDX_CTRL2   6'h10
`define OPDS_IDX_RANGE   6'h11
`define OPDS_IDX_STATUS  6'h20

// reset values
`define OPDS_RST_B_DLY   8'h00
`define OPDS_RST_C_DLY   8'h00
`define OPDS_RST_CTRL1   8'haa
`define OPDS_RST_CTRL2   8'h0a

// field positions
`define OPDS_DLY_OFF     4
`define OPDS_DLY_ON      0
`define OPDS_C1_B_OD     7
`define OPDS_C1_B_GATE   5
`define OPDS_C1_B_LVL    4
`define OPDS_C1_A_OD     3
`define OPDS_C1_A_GATE   1
`define OPDS_C1_A_LVL    0
`define OPDS_C2_C_FN     5
`define OPDS_C2_B_FN     4
`define OPDS_C2_C_OD     3
`define OPDS_C2_C_GATE   1
`define OPDS_C2_C_LVL    0
`define OPDS_RNG_ON      1
`define OPDS_RNG_OFF     0
`define OPDS_RNG_POS     6

// timing
`define OPDS_CLK_MHZ     100
`define OPDS_STEP_LO_US  500
`define OPDS_STEP_HI_US  1000
`define OPDS_CODE_MAX    15
`define OPDS_CNT_W       21

// bus answers
`define OPDS_RESP_OKAY   2'h0
`define OPDS_RESP_SLVERR 2'h2

`endif

// ==== test/opds_far_side.sv ====
/*
  Far-side model: drives the three enable pins and a slow clock on the
  shared clock pin, and loads each output pin with a pull-up.
  Assumes the bench sets the enable pattern just after a clock edge.
*/
`timescale 1ns/1ns

module opds_far_side (
  input  wire logic       core_clk,
  input  wire logic [2:0] en_req,
  input  wire logic [2:0] drv_o,
  input  wire logic [2:0] drv_oe,
  output logic            enable_pin_one,
  output logic            enable_pin_two,
  output logic            enable_pin_three,
  output logic            ext_sync_clock_pin,
  output logic [2:0]      pin_lvl
);
  logic [3:0] div_r = 4'h0;

  // enable pins follow the requested pattern
  assign enable_pin_one   = en_req[0];
  assign enable_pin_two   = en_req[1];
  assign enable_pin_three = en_req[2];

  // pull-up load: a released pin floats high
  assign pin_lvl = (drv_o & drv_oe) | ~drv_oe;

  // free-running clock on the shared pin, unrelated to the outputs
  always_ff @(posedge core_clk) begin
    div_r <= div_r + 4'h1;
  end
  assign ext_sync_clock_pin = div_r[3];
endmodule // opds_far_side

// ==== test/tb.sv ====
/*
  Self-checking bench of the output pin delay sequencer: an AXI4-Lite
  master, one task per scenario. Assumes short delay steps of 4 and 8.
*/
`timescale 1ns/1ns
`include "opds_regs.svh"

module tb
  import opds_pkg::*;
;
  localparam int LO = 4;
  localparam int HI = 8;
  logic        core_clk, sys_rst, clk_en, power_good_b;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        enable_pin_one, enable_pin_two, enable_pin_three;
  logic        ext_sync_clock_pin;
  logic [7:0]  otp_b_delay, otp_c_delay, otp_ctrl_first, otp_ctrl_second;
  logic        output_a_o, output_a_oe, output_b_o, output_b_oe;
  logic        output_c_o, output_c_oe;
  logic [2:0]  en_req, pin_lvl;
  logic [7:0]  rd;
  int          miscompares = 0;
  int          comparisons = 0;
  int          k;

  opds_top #(.STEP_LO_CYC(LO), .STEP_HI_CYC(HI)) dut (
    .core_clk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enable_pin_one,
    .enable_pin_two, .enable_pin_three, .ext_sync_clock_pin,
    .power_good_b, .otp_b_delay, .otp_c_delay, .otp_ctrl_first,
    .otp_ctrl_second, .output_a_o, .output_a_oe, .output_b_o,
    .output_b_oe, .output_c_o, .output_c_oe);

  opds_far_side far (
    .core_clk, .en_req, .enable_pin_one, .enable_pin_two,
    .enable_pin_three, .ext_sync_clock_pin, .pin_lvl,
    .drv_o({output_c_o, output_b_o, output_a_o}),
    .drv_oe({output_c_oe, output_b_oe, output_a_oe}));

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // compare one byte and count it
  task automatic check(input string what, input logic [7:0] want,
                       input logic [7:0] got);
    comparisons++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, want, got);
    end
  endtask

  // one write; returns right after the response edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic aw, w, b;
    int   n;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (b && n < 100) begin
      @(posedge core_clk);
      n++;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        b = 1'b0;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (b) miscompares++;
  endtask

  // one read; data lands in rd and resp
  task automatic rdr(input logic [7:0] idx);
    logic a, r;
    int   n;
    a = 1'b1;
    r = 1'b1;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (r && n < 100) begin
      @(posedge core_clk);
      n++;
      if (a && s_axi_arready) begin
        a = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        r = 1'b0;
        rd = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (r) miscompares++;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // count edges until a pin shows the wanted level
  task automatic wait_pin(input int i, input logic lvl);
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (pin_lvl[i] !== lvl && k < 300);
  endtask

  task automatic t_otp;
    rdr(8'h0d); check("b delay", 8'h21, rd);
    rdr(8'h0e); check("c delay", 8'h12, rd);
    rdr(8'h0f); check("ctrl first", 8'h01, rd);
    rdr(8'h10); check("ctrl second", 8'h30, rd);
    settle(2);
    check("pins", 8'h01, {5'h0, pin_lvl});
  endtask

  task automatic t_bus;
    wr(8'h3f, 8'h55); check("wr resp", 8'h02, {6'h0, resp});
    rdr(8'h3f); check("rd resp", 8'h02, {6'h0, resp});
    check("rd data", 8'h00, rd);
    wr(8'h10, 8'hc0);
    rdr(8'h10); check("ctrl second", 8'hc0, rd);
    // a write without its byte strobe answers okay and stores nothing
    s_axi_wstrb <= 4'h0;
    wr(8'h10, 8'h00);
    check("nostb resp", 8'h00, {6'h0, resp});
    rdr(8'h10);
    check("no strobe", 8'hc0, rd);
    s_axi_wstrb <= 4'h1;
    @(posedge core_clk);
    power_good_b <= 1'b0;
    settle(3); check("pin b pgood lo", 8'h00, {7'h0, pin_lvl[1]});
    check("pin c oe", 8'h00, {7'h0, output_c_oe});
    @(posedge core_clk);
    power_good_b <= 1'b1;
    settle(3);
    check("pin b pgood hi", 8'h03,
          {6'h0, output_b_oe, pin_lvl[1]});
  endtask

  task automatic t_gate_a;
    logic [2:0] pat;
    logic       want;
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        pat = p[0] ? 3'b101 : 3'b010;
        @(posedge core_clk);
        en_req <= pat;
        wr(8'h0f, {5'h0, s[1:0], 1'b1});
        settle(5);
        want = (s == 0) ? 1'b1 : pat[s-1];
        check("pin a", {7'h0, want}, {7'h0, pin_lvl[0]});
      end
    end
    wr(8'h0f, 8'h08); settle(3);
    check("a od low", 8'h02, {6'h0, output_a_oe, output_a_o});
    wr(8'h0f, 8'h09); settle(3);
    check("a od high", 8'h00, {6'h0, output_a_oe, output_a_o});
  endtask

  task automatic t_delay_b;
    @(posedge core_clk);
    en_req <= 3'b000;
    wr(8'h10, 8'h30);
    wr(8'h0d, 8'h23);
    wr(8'h0f, 8'h50);
    settle(20); check("b gated off", 8'h00, {7'h0, pin_lvl[1]});
    // enable pin two rises: two sync stages, the count, then the pin flop
    @(posedge core_clk);
    en_req <= 3'b010;
    wait_pin(1, 1'b1);
    check("b gated on", 8'(3*LO+4), k[7:0]);
    wr(8'h0f, 8'h00);
    wait_pin(1, 1'b0); check("b off delay", 8'(2*LO+1), k[7:0]);
    wr(8'h0f, 8'h10);
    wait_pin(1, 1'b1); check("b on delay", 8'(3*LO+1), k[7:0]);
    wr(8'h0f, 8'h90); settle(20);
    check("b od high", 8'h00, {6'h0, output_b_oe, output_b_o});
  endtask

  task automatic t_range_c;
    wr(8'h11, 8'h80);
    wr(8'h0e, 8'h21);
    wr(8'h10, 8'h31);
    wait_pin(2, 1'b1); check("c on delay", 8'(HI+1), k[7:0]);
    wr(8'h11, 8'h40);
    wr(8'h10, 8'h30);
    wait_pin(2, 1'b0); check("c off delay", 8'(2*HI+1), k[7:0]);
    wr(8'h10, 8'h39); settle(12);
    check("c od high", 8'h00, {6'h0, output_c_oe, output_c_o});
  endtask

  // a low clock enable stretches a running delay; status shows levels
  task automatic t_hold;
    wr(8'h10, 8'h31);
    wr(8'h10, 8'h30);
    clk_en <= 1'b0;
    repeat (10) @(posedge core_clk);
    clk_en <= 1'b1;
    wait_pin(2, 1'b0);
    check("c off frozen", 8'(2*HI+1), k[7:0]);
    rdr(8'h20);
    check("status", 8'h46, rd & 8'hdf);
  endtask

  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence: reset, then the scenarios
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    power_good_b = 1'b1;
    en_req = 3'b000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'h1;
    otp_b_delay = 8'h21;
    otp_c_delay = 8'h12;
    otp_ctrl_first = 8'h01;
    otp_ctrl_second = 8'h30;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_otp;
    t_bus;
    t_gate_a;
    t_delay_b;
    t_range_c;
    t_hold;
    complete_run;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge core_clk);
    miscompares++;
    complete_run;
  end
endmodule // tb
